// ---- hw/tpc_top.sv ----
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module tpc_top
  import tpc_pkg::*;
  #(parameter int BUF_MAX = 128)
  (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Framer side
  input wire logic TX_CLK_I,
  input wire logic TX_DATA_I,
  input wire logic TX_POS_I,
  input wire logic TX_NEG_I,
  // Line side
  output logic LINE_POS_O,
  output logic LINE_NEG_O,
  output logic LINE_OE_O,
  output logic TX_POWER_DOWN_O,
  output logic [15:0] CORNER_MHZ_O
  );
  import tpc_pkg::*;

  initial
  begin
    if (BUF_MAX != TPC_DEPTH_128)
    begin
      $error("tpc_top buffer must hold 128 bits");
    end
  end

  // Configuration registers
  logic [7:0] link_standard_select_reg;
  logic [7:0] tx_jitter_attenuator_config;
  logic [7:0] tx_config_zero;
  logic link_standard_select;
  logic jitter_measure_mode;
  logic wide_bandwidth_limit;
  logic attenuator_enable;
  logic [1:0] attenuator_depth;
  logic attenuator_bandwidth;
  logic tx_off;
  logic transmit_data_invert;
  logic transmit_clock_edge_select;
  logic [1:0] transmitter_stage_mode;

  assign link_standard_select = link_standard_select_reg[TPC_BIT_STD];
  assign jitter_measure_mode = tx_jitter_attenuator_config[TPC_BIT_MEAS_MODE];
  assign wide_bandwidth_limit = tx_jitter_attenuator_config[TPC_BIT_LIMIT];
  assign attenuator_enable = tx_jitter_attenuator_config[TPC_BIT_JA_EN];
  assign attenuator_depth = tx_jitter_attenuator_config[TPC_BIT_DEPTH +: 2];
  assign attenuator_bandwidth = tx_jitter_attenuator_config[TPC_BIT_BW];
  assign tx_off = tx_config_zero[TPC_BIT_TX_OFF];
  assign transmit_data_invert = tx_config_zero[TPC_BIT_INV];
  assign transmit_clock_edge_select = tx_config_zero[TPC_BIT_EDGE];
  assign transmitter_stage_mode = tx_config_zero[TPC_BIT_MODE +: 2];

  // Bus address phase capture
  logic wr_pend;
  logic rd_pend;
  logic [9:0] ph_addr;
  logic take;
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= '0;
    end
    else
    begin
      wr_pend <= take && HWRITE_I;
      rd_pend <= take && !HWRITE_I;
      if (take)
      begin
        ph_addr <= HADDR_I[9:0];
      end
    end
  end

  // Zero wait states, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // Register writes; reserved bits kept zero
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      link_standard_select_reg <= TPC_RST_LINK_STD;
      tx_jitter_attenuator_config <= TPC_RST_JA_CFG;
      tx_config_zero <= TPC_RST_TX_CFG0;
    end
    else if (wr_pend)
    begin
      if (ph_addr == tpc_addr(TPC_IDX_LINK_STD))
      begin
        link_standard_select_reg <= {7'h00, HWDATA_I[0]};
      end
      if (ph_addr == tpc_addr(TPC_IDX_JA_CFG))
      begin
        tx_jitter_attenuator_config <= {2'b00, HWDATA_I[5:0]};
      end
      if (ph_addr == tpc_addr(TPC_IDX_TX_CFG0))
      begin
        tx_config_zero <= {3'b000, HWDATA_I[4:0]};
      end
    end
  end

  // Transmit clock and both rails synchronised as one group; data synchronised on its own
  logic [2:0] pin_sync;
  logic tclk_s;
  logic tclk_d;
  logic tx_edge;
  tpc_sync #(.WIDTH(3)) u_sync_clk (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .raw_i({TX_CLK_I, TX_POS_I, TX_NEG_I}),
    .level_o(pin_sync)
  );
  logic [2:0] sync_dat;
  tpc_sync #(.WIDTH(1)) u_sync_dat (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .raw_i(TX_DATA_I),
    .level_o(sync_dat[0])
  );
  assign sync_dat[2:1] = pin_sync[1:0];
  assign tclk_s = pin_sync[2];

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      tclk_d <= 1'b0;
    end
    else
    begin
      tclk_d <= tclk_s;
    end
  end

  // Chosen edge of the transmit clock
  assign tx_edge = transmit_clock_edge_select ? (tclk_s && !tclk_d)
                                              : (!tclk_s && tclk_d);

  // Sampled and polarity-corrected input
  logic s_data;
  logic s_pos;
  logic s_neg;
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      s_data <= 1'b0;
      s_pos <= 1'b0;
      s_neg <= 1'b0;
    end
    else if (tx_edge)
    begin
      s_data <= sync_dat[0] ^ transmit_data_invert;
      s_pos <= sync_dat[2] ^ transmit_data_invert;
      s_neg <= sync_dat[1] ^ transmit_data_invert;
    end
  end

  // Bit strobe one cycle after the sampling edge
  logic bit_en;
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      bit_en <= 1'b0;
    end
    else
    begin
      bit_en <= tx_edge;
    end
  end

  logic enc_pos;
  logic enc_neg;
  tpc_encoder u_enc (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .bit_en_i(bit_en),
    .data_i(s_data),
    .pos_i(s_pos),
    .neg_i(s_neg),
    .mode_i(transmitter_stage_mode),
    .t1_i(link_standard_select),
    .pos_o(enc_pos),
    .neg_o(enc_neg)
  );

  // Elastic buffer; a fixed fill delay stands for the attenuator
  logic [1:0] buf_mem [BUF_MAX];
  logic [6:0] wr_ptr;
  logic [7:0] depth;
  logic [7:0] half;
  logic [6:0] rd_ptr;
  assign depth = tpc_depth(attenuator_depth);
  assign half = depth >> 1;
  assign rd_ptr = wr_ptr - half[6:0];

  always_ff @(posedge CLK_I)
  begin
    if (bit_en)
    begin
      buf_mem[wr_ptr] <= {enc_pos, enc_neg};
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      wr_ptr <= '0;
    end
    else if (bit_en)
    begin
      wr_ptr <= wr_ptr + 7'd1;
    end
  end

  // Line output; power-down floats the driver
  logic [1:0] ja_out;
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ja_out <= '0;
    end
    else if (bit_en)
    begin
      ja_out <= attenuator_enable ? buf_mem[rd_ptr] : {enc_pos, enc_neg};
    end
  end

  assign LINE_POS_O = ja_out[1] && !tx_off;
  assign LINE_NEG_O = ja_out[0] && !tx_off;
  assign LINE_OE_O = !tx_off;
  assign TX_POWER_DOWN_O = tx_off;

  // Corner frequency report
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      CORNER_MHZ_O <= '0;
    end
    else
    begin
      case ({attenuator_bandwidth, link_standard_select})
        2'b00: CORNER_MHZ_O <= TPC_BW_E1_NORM;
        2'b01: CORNER_MHZ_O <= TPC_BW_T1_NARROWLESS;
        2'b10: CORNER_MHZ_O <= TPC_BW_E1_LOW;
        default: CORNER_MHZ_O <= TPC_BW_T1_LOW;
      endcase
    end
  end

  // Jitter measure: clock cycles between bit strobes, deviation from last
  logic [7:0] period_cnt;
  logic [7:0] last_period;
  logic [7:0] dev;
  logic [7:0] jit_meas;
  logic meas_read;
  assign dev = (period_cnt > last_period) ? period_cnt - last_period
                                          : last_period - period_cnt;
  assign meas_read = rd_pend && ph_addr == tpc_addr(TPC_IDX_JIT_MEAS);

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      period_cnt <= '0;
      last_period <= '0;
      jit_meas <= '0;
    end
    else
    begin
      period_cnt <= bit_en ? 8'd1 : period_cnt + 8'd1;
      if (bit_en)
      begin
        last_period <= period_cnt;
        if (!jitter_measure_mode)
        begin
          jit_meas <= dev;
        end
        else if (meas_read)
        begin
          jit_meas <= dev;
        end
        else if (dev > jit_meas)
        begin
          jit_meas <= dev;
        end
      end
      else if (meas_read && jitter_measure_mode)
      begin
        jit_meas <= '0;
      end
    end
  end

  // Read data mux; unmapped reads as zero
  always_comb
  begin
    HRDATA_O = 32'h0000_0000;
    if (rd_pend)
    begin
      if (ph_addr == tpc_addr(TPC_IDX_LINK_STD))
      begin
        HRDATA_O = {24'h00_0000, link_standard_select_reg};
      end
      else if (ph_addr == tpc_addr(TPC_IDX_JA_CFG))
      begin
        HRDATA_O = {24'h00_0000, tx_jitter_attenuator_config};
      end
      else if (ph_addr == tpc_addr(TPC_IDX_TX_CFG0))
      begin
        HRDATA_O = {24'h00_0000, tx_config_zero};
      end
      else if (ph_addr == tpc_addr(TPC_IDX_JIT_MEAS))
      begin
        HRDATA_O = {24'h00_0000, jit_meas};
      end
    end
  end

  // Checks
  AST_STD_RESET: assert property (@(posedge CLK_I) $rose(ARST_N_I) |-> !link_standard_select)
    else $error("standard select not E1 after reset");
  AST_LIMIT_RESET: assert property (@(posedge CLK_I) $rose(ARST_N_I) |-> wide_bandwidth_limit)
    else $error("limit bit not set after reset");
  AST_OE_OFF: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) tx_off |-> !LINE_OE_O && !LINE_POS_O && !LINE_NEG_O)
    else $error("driver active while powered down");
  AST_RISE: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) tx_edge && transmit_clock_edge_select |-> tclk_s && !tclk_d)
    else $error("wrong sampling edge");
  AST_FALL: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) tx_edge && !transmit_clock_edge_select |-> $fell(tclk_s))
    else $error("wrong sampling edge");
  AST_INV: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) tx_edge && $stable(transmit_data_invert) |=> s_data == ($past(sync_dat[0]) ^ transmit_data_invert))
    else $error("data polarity wrong");
  AST_DEPTH: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) attenuator_depth == 2'b01 |-> depth == 8'd64)
    else $error("depth code wrong");
  AST_CORNER: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) $stable({attenuator_bandwidth, link_standard_select}) && !attenuator_bandwidth && link_standard_select |=> CORNER_MHZ_O == TPC_BW_T1_NARROWLESS)
    else $error("corner frequency wrong");
  AST_BYPASS: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) bit_en && !attenuator_enable |=> ja_out == $past({enc_pos, enc_neg}))
    else $error("bypass path altered data");
  AST_REALTIME: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) bit_en && !jitter_measure_mode |=> jit_meas == $past(dev))
    else $error("real time jitter not refreshed");
  COV_WRITE: cover property (@(posedge CLK_I) wr_pend);
  COV_JA: cover property (@(posedge CLK_I) bit_en && attenuator_enable);
  COV_DUAL: cover property (@(posedge CLK_I) bit_en && transmitter_stage_mode[1]);
  COV_OFF: cover property (@(posedge CLK_I) tx_off);
endmodule

// ---- hw/tpc_pkg.sv ----
package tpc_pkg;
  // Register word indices (printed offsets are not all multiples of four,
  // so they are kept as indices)
  localparam logic [7:0] TPC_IDX_LINK_STD = 8'h20;
  localparam logic [7:0] TPC_IDX_JA_CFG = 8'h21;
  localparam logic [7:0] TPC_IDX_TX_CFG0 = 8'h22;
  localparam logic [7:0] TPC_IDX_JIT_MEAS = 8'h30;

  // Field positions
  localparam int TPC_BIT_STD = 0;
  localparam int TPC_BIT_MEAS_MODE = 5;
  localparam int TPC_BIT_LIMIT = 4;
  localparam int TPC_BIT_JA_EN = 3;
  localparam int TPC_BIT_DEPTH = 1;
  localparam int TPC_BIT_BW = 0;
  localparam int TPC_BIT_TX_OFF = 4;
  localparam int TPC_BIT_INV = 3;
  localparam int TPC_BIT_EDGE = 2;
  localparam int TPC_BIT_MODE = 0;

  // Reset values
  localparam logic [7:0] TPC_RST_LINK_STD = 8'h00;
  localparam logic [7:0] TPC_RST_JA_CFG = 8'h10;
  localparam logic [7:0] TPC_RST_TX_CFG0 = 8'h00;

  // Buffer depths per depth code
  localparam int TPC_DEPTH_128 = 128;
  localparam int TPC_DEPTH_64 = 64;
  localparam int TPC_DEPTH_32 = 32;

  // Corner frequencies in millihertz, reported for the shaping loop
  localparam logic [15:0] TPC_BW_T1_NARROWLESS = 16'h1388; // 5000 mHz
  localparam logic [15:0] TPC_BW_E1_NORM = 16'h1A72; // 6770 mHz
  localparam logic [15:0] TPC_BW_T1_LOW = 16'h04EC; // 1260 mHz
  localparam logic [15:0] TPC_BW_E1_LOW = 16'h0366; // 870 mHz

  typedef enum logic [1:0] {
    TPC_MD_ZS = 2'b00,
    TPC_MD_AMI = 2'b01,
    TPC_MD_DUAL = 2'b10,
    TPC_MD_DUAL2 = 2'b11
  } tpc_mode_t;

  // Byte address of a register index
  function automatic logic [9:0] tpc_addr(input logic [7:0] idx);
    tpc_addr = {idx, 2'b00};
  endfunction

  // Buffer depth of a depth code
  function automatic logic [7:0] tpc_depth(input logic [1:0] code);
    case (code)
      2'b00: tpc_depth = 8'(TPC_DEPTH_128);
      2'b01: tpc_depth = 8'(TPC_DEPTH_64);
      default: tpc_depth = 8'(TPC_DEPTH_32);
    endcase
  endfunction
endpackage

// ---- hw/tpc_sync.sv ----
`timescale 1ns/100ps
module tpc_sync
  #(parameter int WIDTH = 3)
  (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Raw and filtered level
  input wire logic [WIDTH-1:0] raw_i,
  output logic [WIDTH-1:0] level_o
  );
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("tpc_sync width must be positive");
    end
  end

  // Three flops; change accepted once second and third agree
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1 <= raw_i;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
        begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// ---- hw/tpc_encoder.sv ----
`timescale 1ns/100ps
module tpc_encoder
  import tpc_pkg::*;
  (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bit strobe and data
  input wire logic bit_en_i,
  input wire logic data_i,
  input wire logic pos_i,
  input wire logic neg_i,
  // Configuration
  input wire logic [1:0] mode_i,
  input wire logic t1_i,
  // Encoded rails
  output logic pos_o,
  output logic neg_o
  );
  logic last_pol;
  logic [2:0] zeros;
  logic ones_odd;
  logic [6:0] pend_p;
  logic [6:0] pend_n;

  // Zero-run substitution; output delayed seven bits so B8ZS can rewrite
  // the whole run, which keeps the delay equal in HDB3 and AMI modes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      last_pol <= 1'b0;
      zeros <= '0;
      ones_odd <= 1'b0;
      pend_p <= '0;
      pend_n <= '0;
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end
    else if (bit_en_i)
    begin
      pos_o <= pend_p[6];
      neg_o <= pend_n[6];
      if (mode_i[1])
      begin
        // Dual rail bypass
        pend_p <= {pend_p[5:0], pos_i};
        pend_n <= {pend_n[5:0], neg_i};
      end
      else if (data_i)
      begin
        last_pol <= ~last_pol;
        zeros <= '0;
        ones_odd <= ~ones_odd;
        pend_p <= {pend_p[5:0], ~last_pol};
        pend_n <= {pend_n[5:0], last_pol};
      end
      else if (mode_i == 2'b00 && !t1_i && zeros == 3'd3)
      begin
        // HDB3: 000V or B00V
        zeros <= '0;
        ones_odd <= 1'b0;
        if (ones_odd)
        begin
          pend_p <= {pend_p[5:0], last_pol};
          pend_n <= {pend_n[5:0], ~last_pol};
        end
        else
        begin
          last_pol <= ~last_pol;
          pend_p <= {pend_p[5:3], ~last_pol, 2'b00, ~last_pol};
          pend_n <= {pend_n[5:3], last_pol, 2'b00, last_pol};
        end
      end
      else if (mode_i == 2'b00 && t1_i && zeros == 3'd7)
      begin
        // B8ZS: 000VB0VB on last pulse polarity
        zeros <= '0;
        // First zero of the run leaves now; the other seven are rewritten
        pend_p <= {2'b00, last_pol, ~last_pol, 1'b0, ~last_pol, last_pol};
        pend_n <= {2'b00, ~last_pol, last_pol, 1'b0, last_pol, ~last_pol};
        pos_o <= 1'b0;
        neg_o <= 1'b0;
      end
      else
      begin
        zeros <= zeros + 3'd1;
        pend_p <= {pend_p[5:0], 1'b0};
        pend_n <= {pend_n[5:0], 1'b0};
      end
    end
  end
endmodule

// ---- bench/tpc_framer_model.sv ----
`timescale 1ns/100ps
module tpc_framer_model
  (
  // Control from the bench
  input wire logic run_i,
  input wire logic sample_rise_i,
  input wire logic stretch_i,
  // Next bit as pin levels: data, positive rail, negative rail
  input wire logic [2:0] bits_i,
  // Framer pins
  output logic tx_clk_o,
  output logic tx_data_o,
  output logic tx_pos_o,
  output logic tx_neg_o,
  // Bits handed over so far
  output int bit_cnt_o
  );
  logic [2:0] cur = 3'b000;
  int s;
  int r;

  initial bit_cnt_o = 0;

  // One bit period in eight 10 ns steps
  always
  begin
    s = sample_rise_i ? 0 : 4;
    for (int k = 0; k < 8; k++)
    begin
      r = (k - s + 8) % 8;
      if (r == 6 && run_i)
      begin
        cur = bits_i;
        bit_cnt_o = bit_cnt_o + 1;
      end
      // Clock stands still when idle
      tx_clk_o = run_i && (k < 4);
      // Good data only 20 ns either side of the sampling edge, inverse elsewhere
      {tx_data_o, tx_pos_o, tx_neg_o} = (run_i && (r < 2 || r > 5)) ? cur : ~cur;
      #10;
    end
    // Optional late edge to make jitter
    if (stretch_i)
      #20;
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import tpc_pkg::*;
  localparam logic [31:0] A_STD = 32'({TPC_IDX_LINK_STD, 2'b00});
  localparam logic [31:0] A_JA = 32'({TPC_IDX_JA_CFG, 2'b00});
  localparam logic [31:0] A_CFG = 32'({TPC_IDX_TX_CFG0, 2'b00});
  localparam logic [31:0] A_JIT = 32'({TPC_IDX_JIT_MEAS, 2'b00});
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rdat_q;
  logic hready, hresp, rdy_q;
  logic tx_clk, tx_d, tx_p, tx_n, ln_p, ln_n, ln_oe, pwr_dn;
  logic [15:0] corner;
  logic run = 1'b0;
  logic rise = 1'b0;
  logic stretch = 1'b0;
  logic [2:0] bits = 3'b000;
  int bit_cnt, base, lag;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  tpc_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .TX_CLK_I(tx_clk), .TX_DATA_I(tx_d), .TX_POS_I(tx_p), .TX_NEG_I(tx_n),
    .LINE_POS_O(ln_p), .LINE_NEG_O(ln_n), .LINE_OE_O(ln_oe), .TX_POWER_DOWN_O(pwr_dn),
    .CORNER_MHZ_O(corner));

  tpc_framer_model i_framer (.run_i(run), .sample_rise_i(rise), .stretch_i(stretch),
    .bits_i(bits), .tx_clk_o(tx_clk), .tx_data_o(tx_d), .tx_pos_o(tx_p), .tx_neg_o(tx_n),
    .bit_cnt_o(bit_cnt));

  // Bus answer taken at the edge itself; hang limit
  always @(posedge clk)
  begin
    rdy_q <= hready;
    rdat_q <= hrdata;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Edges until ready is seen high; ends just after an edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rdy_q !== 1'b1 && n < 64);
  endtask

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = rdat_q;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, e);
  endtask

  // Give the framer one bit, sample the line once it has been taken
  task automatic send_bit(input logic [2:0] p, output logic [1:0] ln);
    int c;
    int w;
    c = bit_cnt;
    w = 0;
    bits <= p;
    while (bit_cnt == c && w < 100)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    ln = {ln_p, ln_n};
  endtask

  task automatic reset_test();
    check(32'({ln_oe, pwr_dn, hresp}), 32'h0000_0004);
    check(32'(corner), 32'(TPC_BW_E1_NORM));
    rd_chk(A_STD, 32'h0000_0000);
    rd_chk(A_JA, 32'h0000_0010);
    rd_chk(A_CFG, 32'h0000_0000);
    // Unmapped word ignores writes; reserved bits read zero
    wr(32'h0000_008C, 32'hFFFF_FFFF);
    rd_chk(32'h0000_008C, 32'h0000_0000);
    wr(A_STD, 32'h0000_00FF);
    wr(A_JA, 32'h0000_00FF);
    wr(A_CFG, 32'h0000_00FF);
    rd_chk(A_STD, 32'h0000_0001);
    rd_chk(A_JA, 32'h0000_003F);
    rd_chk(A_CFG, 32'h0000_001F);
  endtask

  task automatic corner_test();
    logic [15:0] tbl [0:3];
    tbl = '{TPC_BW_E1_NORM, TPC_BW_T1_NARROWLESS, TPC_BW_E1_LOW, TPC_BW_T1_LOW};
    for (int i = 0; i < 4; i++)
    begin
      wr(A_STD, 32'(i % 2));
      wr(A_JA, 32'h0000_0010 | 32'(i / 2));
      repeat (4) @(posedge clk);
      #1;
      check(32'(corner), 32'(tbl[i]));
    end
  endtask

  // One mark on the positive rail amid spaces; its delay in bits
  task automatic lag_run(input logic [7:0] ja, input logic [7:0] cfg, output int lg);
    logic [2:0] sp;
    logic [1:0] ln;
    int bad;
    sp = {3{cfg[TPC_BIT_INV]}};
    lg = -1;
    bad = 0;
    rise <= cfg[TPC_BIT_EDGE];
    wr(A_JA, 32'(ja));
    wr(A_CFG, 32'(cfg));
    for (int i = 0; i < 72; i++)
      send_bit(sp, ln);
    send_bit(sp ^ 3'b010, ln);
    for (int i = 1; i < 100; i++)
    begin
      send_bit(sp, ln);
      if (ln == 2'b10 && lg < 0)
        lg = i;
      else if (ln != 2'b00)
        bad++;
    end
    check(32'(bad), 32'h0000_0000);
  endtask

  // Single-rail stream; longest space run and mark pairing in the last 24 symbols
  task automatic code_run(input logic [1:0] md, input logic t1, input logic d,
    input int exp_run, input logic alt);
    logic [1:0] ln;
    logic [1:0] last;
    int run_len;
    int max_run;
    int errs;
    last = 2'b00;
    run_len = 0;
    max_run = 0;
    errs = 0;
    rise <= 1'b0;
    wr(A_STD, 32'(t1));
    wr(A_JA, 32'h0000_0010);
    wr(A_CFG, 32'(md));
    for (int i = 0; i < 48; i++)
    begin
      send_bit({d, 2'b00}, ln);
      if (i >= 24)
      begin
        run_len = (ln == 2'b00) ? run_len + 1 : 0;
        max_run = (run_len > max_run) ? run_len : max_run;
        if (ln == 2'b11 || (alt && ln != 2'b00 && ln == last))
          errs++;
        if (ln != 2'b00)
          last = ln;
      end
    end
    check(32'(max_run), 32'(exp_run));
    check(32'(errs), 32'h0000_0000);
  endtask

  task automatic power_test();
    logic [1:0] ln;
    wr(A_CFG, 32'h0000_0012);
    repeat (20) send_bit(3'b010, ln);
    check(32'({ln_oe, pwr_dn, ln}), 32'h0000_0004);
    wr(A_CFG, 32'h0000_0002);
    repeat (20) send_bit(3'b010, ln);
    check(32'({ln_oe, pwr_dn, ln}), 32'h0000_000A);
  endtask

  // One late edge, then steady bits; accumulation keeps the peak until read
  task automatic jitter_test();
    logic [31:0] v1, v2, x;
    logic [1:0] ln;
    for (int m = 0; m < 2; m++)
    begin
      wr(A_JA, m ? 32'h0000_0030 : 32'h0000_0010);
      bus(1'b0, A_JIT, 32'h0000_0000, x);
      stretch <= 1'b1;
      send_bit(3'b000, ln);
      stretch <= 1'b0;
      repeat (4) send_bit(3'b000, ln);
      bus(1'b0, A_JIT, 32'h0000_0000, v1);
      repeat (4) send_bit(3'b000, ln);
      bus(1'b0, A_JIT, 32'h0000_0000, v2);
      check(32'(v1 >= 32'd3), 32'(m));
      check(32'(v2 < 32'd3), 32'h0000_0001);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    run <= 1'b1;
    reset_test();
    corner_test();
    lag_run(8'h00, 8'h02, base);
    check(32'(base >= 1 && base <= 16), 32'h0000_0001);
    lag_run(8'h08, 8'h02, lag);
    check(32'(lag), 32'(base + 64));
    lag_run(8'h0A, 8'h03, lag);
    check(32'(lag), 32'(base + 32));
    lag_run(8'h0C, 8'h0A, lag);
    check(32'(lag), 32'(base + 16));
    lag_run(8'h0E, 8'h06, lag);
    check(32'(lag), 32'(base + 16));
    code_run(2'b01, 1'b0, 1'b1, 0, 1'b1);
    code_run(2'b01, 1'b1, 1'b0, 24, 1'b0);
    code_run(2'b00, 1'b0, 1'b0, 2, 1'b0);
    code_run(2'b00, 1'b1, 1'b0, 3, 1'b0);
    power_test();
    jitter_test();
    stop_test();
  end
endmodule
